// *** rtl/adc_serial_ctrl.sv ***
// serial control and conversion sequencing of a two-channel 12-bit converter
// assumes pins arrive asynchronously and are sampled by a 100 MHz clock;
// the analog inputs are modelled as already digitised 12-bit codes
//
// What this block does
// - of select bits 5..3, only bit 3 chooses the next conversion's input
// - bits 7..6 and 2..0 ignored
// - mid bit low: low bit picks channel
// - result is 12-bit straight binary code
// - powered while frame low outside sleep, down while high
// - sleeps from 16th fall to next first fall
// - sixteen serial clocks per conversion, back-to-back
// - conversions repeat while frame stays low
// - one result per sixteen serial clocks
// - track three clocks, result MSB first from fifth
// - capture control word on first eight rises
// - output driven only while frame low
// - first conversion after reset uses first input
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_cfg.svh"

module adc_serial_ctrl
  import adc_ctrl_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    frame_select_n,
  input  wire logic                    serial_clock,
  input  wire logic                    serial_in,
  input  wire logic [`RESULT_BITS-1:0] analog_input_first,
  input  wire logic [`RESULT_BITS-1:0] analog_input_second,
  output logic                         serial_out,
  output logic                         serial_out_oe,
  output logic                         powered_up,
  output logic                         tracking,
  output logic                         active_channel
);

  // ***************************************************************
  // state and buffer wiring
  // ***************************************************************
  // st_q holds every flop of the block outside the result buffer, st_d its next value
  ctrl_state_t              st_q;
  ctrl_state_t              st_d;
  logic                     frame;
  logic                     frame_fall;
  logic                     sclk_rise;
  logic                     sclk_fall;
  logic                     push_valid;
  logic [`RESULT_BITS-1:0]  sample;
  logic                     res_valid;
  logic                     res_pop;
  logic [`RESULT_BITS-1:0]  res_data;
  logic [`CTRL_WORD_BITS-1:0] word_next;

  // the link clock is oversampled, so each of its levels must be held
  // two system clocks or more; a shorter level can vanish inside the
  // synchroniser and a rise or fall would be lost
  // edges read only the second synchroniser stage and its delayed copy
  assign frame      = ~st_q.frame_s;
  assign frame_fall = st_q.frame_d & ~st_q.frame_s;
  // serial clock is gated off while the frame is high
  assign sclk_rise  = frame & ~st_q.sclk_d & st_q.sclk_s;
  assign sclk_fall  = frame & st_q.sclk_d & ~st_q.sclk_s;
  // control word shifts in MSB first on each counted rise
  assign word_next  = {st_q.channel_control_word[`CTRL_WORD_BITS-2:0], st_q.sdi_s};

  // held sample of the selected input, straight binary code
  // the analog side is not modelled: the selected code stands for the held voltage
  assign sample     = (st_q.current_channel == `CHANNEL_SECOND) ?
                      analog_input_second : analog_input_first;
  // hold starts on the fourth falling edge: capture sample then;
  // one result per conversion is pushed, so the buffer never fills
  assign push_valid = sclk_fall & (st_q.rise_cnt == 4'(`TRACK_CLOCKS));
  // shifter drains one result as the fifth clock's bit goes out; while the
  // frame is high a result left by a cut frame is dropped, so the next
  // frame never shifts out a stale sample
  assign res_pop    = res_valid &
                      ((sclk_fall & (st_q.rise_cnt == 4'(`LEAD_ZERO_CLOCKS))) | ~frame);

  // ***************************************************************
  // result buffer between sampler and shifter
  // ***************************************************************
  // a late host read stalls the shifter, not the sampler
  result_buffer #(
    .WIDTH (`RESULT_BITS)
  ) u_result_buffer (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (),
    .in_data   (sample),
    .out_valid (res_valid),
    .out_ready (res_pop),
    .out_data  (res_data)
  );

  // ***************************************************************
  // next-state logic
  // ***************************************************************
  // phase walk of one conversion, counted in serial clock rises:
  //   frame fall, or fall after rise 16 -> track
  //   fall after rise 3                  -> hold, sample captured
  //   fall after rise 15                 -> sleep until the next fall
  //   rise 16                            -> next channel applied
  // leaving the frame drops to idle from any phase
  always_comb begin
    st_d = st_q;
    // two-stage synchronisers, plus delayed copies for edges
    st_d.frame_m = frame_select_n;
    st_d.frame_s = st_q.frame_m;
    st_d.frame_d = st_q.frame_s;
    st_d.sclk_m  = serial_clock;
    st_d.sclk_s  = st_q.sclk_m;
    st_d.sclk_d  = st_q.sclk_s;
    st_d.sdi_m   = serial_in;
    st_d.sdi_s   = st_q.sdi_m;

    if (!frame) begin
      // frame high: fully powered down, output floated
      st_d.phase      = PH_IDLE;
      st_d.serial_out = 1'b0;
      st_d.out_shift  = '0;
      // rise and control counters restart at the next frame fall
    end else if (frame_fall) begin
      // frame fall acts as the first falling edge: enter track; with the
      // serial clock high, its later fall re-enters track harmlessly
      st_d.phase      = PH_TRACK;
      st_d.rise_cnt   = 4'h0;
      st_d.ctrl_cnt   = 4'h0;
      st_d.serial_out = 1'b0;
    end else begin
      if (sclk_rise) begin
        // control word is taken on the first eight rises of each conversion
        // rises nine to sixteen leave the word alone
        if (st_q.ctrl_cnt < 4'(`CTRL_WORD_BITS)) begin
          st_d.channel_control_word = word_next;
          st_d.ctrl_cnt             = st_q.ctrl_cnt + 4'h1;
          if (st_q.ctrl_cnt == 4'(`CTRL_WORD_BITS - 1)) begin
            // only the low select bit matters; top, mid and don't-care bits drop
            st_d.pending_channel = word_next[`CTRL_SEL_LOW_BIT];
          end
        end
        // count wraps at sixteen so conversions run back to back
        st_d.rise_cnt = st_q.rise_cnt + 4'h1;
        if (st_q.rise_cnt == 4'(`CONV_CLOCKS - 1)) begin
          // new selection takes effect for the following conversion only
          st_d.current_channel = st_q.pending_channel;
          st_d.ctrl_cnt        = 4'h0;
        end
      end
      if (sclk_fall) begin
        case (st_q.rise_cnt)
          4'(`TRACK_CLOCKS): begin
            st_d.phase = PH_HOLD;
          end
          4'(`CONV_CLOCKS - 1): begin
            st_d.phase = PH_SLEEP;
          end
          4'h0: begin
            // first falling edge of the next conversion wakes the converter
            st_d.phase = PH_TRACK;
          end
          default: begin
            st_d.phase = st_q.phase;
          end
        endcase
        // four leading zeros, then twelve result bits, MSB first
        // with no result waiting, zeros go out rather than stale bits
        if (st_q.rise_cnt < 4'(`LEAD_ZERO_CLOCKS)) begin
          st_d.serial_out = 1'b0;
        end else if (st_q.rise_cnt == 4'(`LEAD_ZERO_CLOCKS)) begin
          st_d.serial_out = res_valid ? res_data[`RESULT_BITS-1] : 1'b0;
          st_d.out_shift  = res_valid ? {res_data[`RESULT_BITS-2:0], 1'b0} : '0;
        end else begin
          st_d.serial_out = st_q.out_shift[`RESULT_BITS-1];
          st_d.out_shift  = {st_q.out_shift[`RESULT_BITS-2:0], 1'b0};
        end
      end
    end

    // registered pin and status outputs
    st_d.serial_out_oe  = ~st_d.frame_s;
    st_d.powered_up     = (st_d.phase == PH_TRACK) || (st_d.phase == PH_HOLD);
    st_d.tracking       = (st_d.phase == PH_TRACK);
    st_d.active_channel = st_d.current_channel;
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  // reset starts on the first input with no dummy conversion needed
  // synchroniser stages start at the idle pin levels, so no false edge follows
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q                      <= '0;
      st_q.frame_m              <= 1'b1;
      st_q.frame_s              <= 1'b1;
      st_q.frame_d              <= 1'b1;
      st_q.phase                <= PH_IDLE;
      st_q.channel_control_word <= `CTRL_WORD_RESET;
      st_q.pending_channel      <= `CHANNEL_FIRST;
      st_q.current_channel      <= `CHANNEL_FIRST;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************************
  // pins and status, straight from the state register
  // ***************************************************************
  // no logic between flop and pin, so the host never sees a glitch
  assign serial_out     = st_q.serial_out;
  assign serial_out_oe  = st_q.serial_out_oe;
  assign powered_up     = st_q.powered_up;
  assign tracking       = st_q.tracking;
  assign active_channel = st_q.active_channel;

endmodule

`default_nettype wire

// *** rtl/adc_ctrl_cfg.svh ***
// constants for the two-channel converter serial control block
// assumes inclusion by bare name from package and design files
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

// control word layout
`define CTRL_WORD_BITS      8
`define CTRL_SEL_TOP_BIT    5
`define CTRL_SEL_MID_BIT    4
`define CTRL_SEL_LOW_BIT    3
// conversion timing in serial clocks
`define CONV_CLOCKS         16
`define TRACK_CLOCKS        3
`define LEAD_ZERO_CLOCKS    4
`define RESULT_BITS         12
// channel codes and reset values
`define CHANNEL_FIRST       1'h0
`define CHANNEL_SECOND      1'h1
`define CTRL_WORD_RESET     8'h00
// fastest serial clock the host may run, in MHz
`define SERIAL_CLOCK_MAX_MHZ 16

`endif

// *** rtl/adc_ctrl_pkg.sv ***
// types shared by the converter serial control files
// assumes adc_ctrl_cfg.svh on the include path
`include "adc_ctrl_cfg.svh"

package adc_ctrl_pkg;

  // converter phase, gray along idle-track-hold-sleep
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_TRACK = 2'b01,
    PH_HOLD  = 2'b11,
    PH_SLEEP = 2'b10
  } phase_t;

  typedef struct packed {
    logic                          frame_m;
    logic                          frame_s;
    logic                          frame_d;
    logic                          sclk_m;
    logic                          sclk_s;
    logic                          sclk_d;
    logic                          sdi_m;
    logic                          sdi_s;
    phase_t                        phase;
    logic [3:0]                    rise_cnt;
    logic [3:0]                    ctrl_cnt;
    logic [`CTRL_WORD_BITS-1:0]    channel_control_word;
    logic                          pending_channel;
    logic                          current_channel;
    logic [`RESULT_BITS-1:0]       out_shift;
    logic                          serial_out;
    logic                          serial_out_oe;
    logic                          powered_up;
    logic                          tracking;
    logic                          active_channel;
  } ctrl_state_t;

endpackage

// *** rtl/result_buffer.sv ***
// two-entry result buffer with valid/ready on both sides
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module result_buffer #(
  parameter int WIDTH = 12
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  wr_ptr;
    logic                  rd_ptr;
    logic [1:0]            count;
  } buf_state_t;

  buf_state_t buf_q;
  buf_state_t buf_d;
  logic       push;
  logic       pop;

  // ***************************************************************
  // flags and next state
  // ***************************************************************
  assign in_ready  = (buf_q.count != 2'h2);
  assign out_valid = (buf_q.count != 2'h0);
  assign out_data  = buf_q.mem[buf_q.rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // a push into a full buffer is refused, never overwrites
  always_comb begin
    buf_d = buf_q;
    if (push) begin
      buf_d.mem[buf_q.wr_ptr] = in_data;
      buf_d.wr_ptr = ~buf_q.wr_ptr;
    end
    if (pop) begin
      buf_d.rd_ptr = ~buf_q.rd_ptr;
    end
    case ({push, pop})
      2'b10:   buf_d.count = buf_q.count + 2'h1;
      2'b01:   buf_d.count = buf_q.count - 2'h1;
      default: buf_d.count = buf_q.count;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      buf_q <= '0;
    end else begin
      buf_q <= buf_d;
    end
  end

endmodule

`default_nettype wire

// *** test/host_model.sv ***
// host side of the serial link: frame select, serial clock, control word
// assumes the converter control block samples these pins with its own clock
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic clock,
  input  wire logic serial_out,
  output var  logic frame_select_n,
  output var  logic serial_clock,
  output var  logic serial_in
);
  // ****************
  // link driver
  // ****************
  // half period in system clocks: 4 gives the 80 ns, 12.5 MHz link clock
  int hp = 4;

  // idle pins at time zero: frame high, clock parked low
  initial begin
    frame_select_n = 1'b1;
    serial_clock   = 1'b0;
    serial_in      = 1'b0;
  end

  // frame fall with the clock low counts as the first falling edge
  task automatic open_frame();
    frame_select_n <= 1'b0;
  endtask

  // clock stays high after rise 16 so no stray track starts before frame rise
  task automatic close_frame();
    repeat (hp) @(posedge clock);
    frame_select_n <= 1'b1;
    repeat (hp) @(posedge clock);
    serial_clock <= 1'b0;
  endtask

  // one conversion: sixteen rises, word MSB first, result sampled late in high phase
  task automatic conv(input logic [7:0] w, output logic [11:0] r);
    for (int k = 1; k <= 16; k++) begin
      serial_clock <= 1'b0;
      serial_in    <= (k <= 8) ? w[8-k] : k[0];
      repeat (hp) @(posedge clock);
      serial_clock <= 1'b1;
      repeat (hp) @(posedge clock);
      if (k >= 5) r[16-k] = serial_out;
    end
  endtask
endmodule

`default_nettype wire

// *** test/adc_serial_ctrl_checker.sv ***
// pin relations of the converter serial control block
// assumes a bind onto adc_serial_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none

module adc_serial_ctrl_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic frame_select_n,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic powered_up,
  input wire logic tracking,
  input wire logic active_channel
);
  // ****************
  // assertions, pin synchroniser lag is under five clocks
  // ****************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_oe_off_high: assert property (frame_select_n [*5] |-> !serial_out_oe)
    else $error("output driven while frame high");
  a_oe_on_low: assert property (!frame_select_n [*5] |-> serial_out_oe)
    else $error("output not driven while frame low");
  a_out_quiet: assert property (!serial_out_oe && !$past(serial_out_oe) |-> !serial_out)
    else $error("data seen with output disabled");
  a_power_off: assert property (frame_select_n [*5] |-> !powered_up)
    else $error("powered while frame high");
  a_track_power: assert property ($fell(tracking) && serial_out_oe |-> powered_up)
    else $error("track not followed by hold");
  a_chan_sleep: assert property ($changed(active_channel) |-> !powered_up)
    else $error("channel changed inside a conversion");
  a_track_len: assert property ($rose(tracking) |-> tracking [*8])
    else $error("track phase too short");
  a_sleep_len: assert property ($fell(powered_up) |-> !powered_up [*4])
    else $error("sleep too short");
  a_sleep_end: assert property ($fell(powered_up) |-> ##[1:40] (powered_up || !serial_out_oe))
    else $error("sleep did not end at next conversion");

  // main scenarios reached
  c_second: cover property ($rose(active_channel));
  c_sleep: cover property ($fell(powered_up) && serial_out_oe);
  c_frame: cover property ($rose(serial_out_oe));
endmodule

bind adc_serial_ctrl adc_serial_ctrl_checker u_adc_serial_ctrl_checker (
  .clock, .rst, .frame_select_n, .serial_out, .serial_out_oe, .powered_up,
  .tracking, .active_channel);

`default_nettype wire

// *** test/adc_serial_ctrl_test.sv ***
// self-checking bench of the converter serial control block
// assumes host_model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none

module adc_serial_ctrl_test;
  // ****************
  // bench signals
  // ****************
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        frame_select_n, serial_clock, serial_in;
  logic [11:0] first_code = 12'h000;
  logic [11:0] second_code = 12'h000;
  logic        serial_out, serial_out_oe, powered_up, tracking, active_channel;
  int          num_errors = 0;
  int          tests_run = 0;

  always #5 clock = ~clock;

  adc_serial_ctrl u_adc_serial_ctrl (.clock, .rst, .frame_select_n, .serial_clock,
    .serial_in, .analog_input_first(first_code), .analog_input_second(second_code),
    .serial_out, .serial_out_oe, .powered_up, .tracking, .active_channel);
  host_model u_host_model (.clock, .serial_out, .frame_select_n, .serial_clock,
    .serial_in);

  task automatic check(input string what, input logic [11:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one frame of n conversions; chans holds the channel each result must come from
  task automatic run_frame(string name, int n, logic [31:0] words, logic [3:0] chans);
    logic [11:0] r;
    u_host_model.open_frame();
    for (int i = 0; i < n; i++) begin
      u_host_model.conv(words[31-8*i -: 8], r);
      check(name, r, chans[3-i] ? second_code : first_code);
      // the low select bit of the word just sent takes over at rise 16
      check("channel", {11'h000, active_channel}, {11'h000, words[27-8*i]});
    end
    u_host_model.close_frame();
    $display("%s done", name);
  endtask

  // ignored bits set, top select bit set, back-to-back conversions at the 12.5 MHz link clock
  task automatic t_stream();
    @(posedge clock);
    first_code  <= 12'ha5c;
    second_code <= 12'h3a1;
    run_frame("t_stream", 4, 32'hc708_2808, 4'b0011);
  endtask

  // frame without clocks: powered and tracking while low, all quiet once high
  task automatic t_power();
    u_host_model.open_frame();
    repeat (10) @(posedge clock);
    check("pins low", {9'h000, serial_out_oe, powered_up, tracking}, 12'h007);
    u_host_model.close_frame();
    repeat (6) @(posedge clock);
    check("pins high", {8'h00, serial_out, serial_out_oe, powered_up, tracking}, 12'h000);
    $display("t_power done");
  endtask

  // first result keeps the channel chosen in the earlier frame
  task automatic t_keep();
    @(posedge clock);
    first_code  <= 12'hfff;
    second_code <= 12'h000;
    run_frame("t_keep", 2, 32'h2000_0000, 4'b1000);
  endtask

  task automatic end_sim();
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence: reset five clocks, let synchronisers fill, then the tests
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_stream();
    t_power();
    t_keep();
    end_sim();
  end

  // watchdog: the tests need under 2000 clocks
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    end_sim();
  end
endmodule

`default_nettype wire
